// ---- dcs_pkg.sv ----
// package: shared constants and types of the dual channel safety output logic
`default_nettype none
package dcs_pkg;

  // -------------------------------------------------------------------------
  // plausibility monitor states
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    DCS_ST_OK      = 2'b00,
    DCS_ST_UNEQUAL = 2'b01,
    DCS_ST_LOCK    = 2'b10
  } dcs_state_t;

  // -------------------------------------------------------------------------
  // indication encodings
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    DCS_IN_IND_OFF   = 2'b00,
    DCS_IN_IND_ON    = 2'b01,
    DCS_IN_IND_FAST  = 2'b10,
    DCS_IN_IND_FLASH = 2'b11
  } dcs_in_ind_t;

  typedef enum logic [1:0] {
    DCS_DEV_IND_OFF   = 2'b00,
    DCS_DEV_IND_GREEN = 2'b01,
    DCS_DEV_IND_RED   = 2'b10
  } dcs_dev_ind_t;

  // -------------------------------------------------------------------------
  // grouped signals
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic safety_in_a;
    logic safety_in_b;
  } dcs_pair_t;

  typedef struct packed {
    dcs_in_ind_t  input_ind;
    dcs_dev_ind_t device_ind;
  } dcs_ind_t;

  // -------------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------------
  localparam dcs_pair_t  DCS_PAIR_RST  = 2'h0;
  localparam dcs_state_t DCS_STATE_RST = DCS_ST_OK;
  localparam logic [1:0] DCS_EVAL_CYCLES = 2'h2;  // cycles before outputs may rise

endpackage
`default_nettype wire

// ---- dcs_output_logic.sv ----
// module: dual channel safety output logic with plausibility monitor
//
// Function
// - when actuator present and ready, each output copies its own input
// - no actuator detected forces both safety outputs low
// - without diagnostic link, signal output shows actuator presence
// - one input falls while other stays high: unequal state indicated
// - same input rises again: plausibility error, partial operation lock
// - lock releases only after both inputs seen low together
// - attached fieldbus module enables the diagnostic input automatically
// - without fieldbus module the diagnostic input is ignored
// - in diagnostic mode signal output carries transmit data
// - diagnostic link re-establishes itself after every power-up
`default_nettype none
module dcs_output_logic
  import dcs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire dcs_pkg::dcs_pair_t safety_in,
  input  wire logic              actuator_present,
  input  wire logic              switch_ready,
  input  wire logic              fieldbus_attached,
  input  wire logic              diag_in,
  input  wire logic              diag_tx_data,
  output var  logic              safety_out_a,
  output var  logic              safety_out_b,
  output var  logic              signal_diag_out,
  output var  logic              diag_rx_data,
  output var  logic              diag_rx_valid,
  output var  logic              diag_active,
  output var  logic              plaus_error,
  output var  dcs_pkg::dcs_ind_t indication
);

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  dcs_state_t  state;
  dcs_state_t  next_state;
  dcs_pair_t   prev_in;
  logic        odd_ch;       // channel that dropped: 0 = a, 1 = b
  logic        next_odd_ch;
  logic [1:0]  eval_cnt;
  logic        evaluated;

  // -------------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------------
  wire logic a_fell    = prev_in.safety_in_a & ~safety_in.safety_in_a;
  wire logic b_fell    = prev_in.safety_in_b & ~safety_in.safety_in_b;
  wire logic a_rose    = ~prev_in.safety_in_a & safety_in.safety_in_a;
  wire logic b_rose    = ~prev_in.safety_in_b & safety_in.safety_in_b;
  wire logic both_low  = ~safety_in.safety_in_a & ~safety_in.safety_in_b;
  wire logic odd_rose  = odd_ch ? b_rose : a_rose;
  wire logic other_hi  = odd_ch ? safety_in.safety_in_a : safety_in.safety_in_b;
  wire logic a_drop    = a_fell & prev_in.safety_in_b & safety_in.safety_in_b;
  wire logic b_drop    = b_fell & prev_in.safety_in_a & safety_in.safety_in_a;
  wire logic run       = actuator_present & switch_ready & evaluated;
  wire logic pass      = run & (next_state != DCS_ST_LOCK);
  wire logic next_out_a = pass & safety_in.safety_in_a;
  wire logic next_out_b = pass & safety_in.safety_in_b;
  wire logic diag_mode = fieldbus_attached;
  wire logic next_sig  = diag_mode ? diag_tx_data : actuator_present;

  // -------------------------------------------------------------------------
  // plausibility monitor next state
  // -------------------------------------------------------------------------
  always_comb begin
    next_state  = state;
    next_odd_ch = odd_ch;
    case (state)
      DCS_ST_OK: begin
        if (a_drop) begin
          next_state  = DCS_ST_UNEQUAL;
          next_odd_ch = 1'b0;
        end else if (b_drop) begin
          next_state  = DCS_ST_UNEQUAL;
          next_odd_ch = 1'b1;
        end
      end
      DCS_ST_UNEQUAL: begin
        if (both_low) begin
          next_state = DCS_ST_OK;
        end else if (odd_rose && other_hi) begin
          next_state = DCS_ST_LOCK;
        end
      end
      DCS_ST_LOCK: begin
        if (both_low) begin
          next_state = DCS_ST_OK;
        end
      end
      default: begin
        next_state = DCS_ST_LOCK;
      end
    endcase
  end

  // -------------------------------------------------------------------------
  // state registers
  // -------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state   <= DCS_STATE_RST;
      odd_ch  <= 1'b0;
      prev_in <= DCS_PAIR_RST;
    end else begin
      state   <= next_state;
      odd_ch  <= next_odd_ch;
      prev_in <= safety_in;
    end
  end

  // power-up evaluation delay
  always_ff @(posedge clk) begin
    if (srst) begin
      eval_cnt  <= 2'h0;
      evaluated <= 1'b0;
    end else if (!evaluated) begin
      eval_cnt  <= eval_cnt + 2'h1;
      evaluated <= (eval_cnt == DCS_EVAL_CYCLES - 2'h1);
    end
  end

  // -------------------------------------------------------------------------
  // output registers
  // -------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      safety_out_a    <= 1'b0;
      safety_out_b    <= 1'b0;
      signal_diag_out <= 1'b0;
      diag_active     <= 1'b0;
      plaus_error     <= 1'b0;
    end else begin
      safety_out_a    <= next_out_a;
      safety_out_b    <= next_out_b;
      signal_diag_out <= next_sig;
      diag_active     <= diag_mode;
      plaus_error     <= (next_state == DCS_ST_LOCK);
    end
  end

  // diagnostic receive path, dead without a fieldbus module
  always_ff @(posedge clk) begin
    if (srst) begin
      diag_rx_data  <= 1'b0;
      diag_rx_valid <= 1'b0;
    end else begin
      diag_rx_data  <= diag_mode & diag_in;
      diag_rx_valid <= diag_mode;
    end
  end

  // -------------------------------------------------------------------------
  // indication
  // -------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      indication <= {DCS_IN_IND_OFF, DCS_DEV_IND_OFF};
    end else begin
      case (next_state)
        DCS_ST_UNEQUAL: indication <= {DCS_IN_IND_FAST, DCS_DEV_IND_RED};
        DCS_ST_LOCK:    indication <= {DCS_IN_IND_FLASH, DCS_DEV_IND_RED};
        default: begin
          indication.device_ind <= switch_ready ? DCS_DEV_IND_GREEN : DCS_DEV_IND_OFF;
          indication.input_ind  <= (safety_in.safety_in_a & safety_in.safety_in_b)
                                   ? DCS_IN_IND_ON : DCS_IN_IND_OFF;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  sequence s_a_drop;
    state == DCS_ST_OK && prev_in == 2'h3 && safety_in == 2'h1;
  endsequence

  sequence s_a_return;
    state == DCS_ST_UNEQUAL && !odd_ch && prev_in == 2'h1 && safety_in == 2'h3;
  endsequence

  sequence s_b_drop;
    state == DCS_ST_OK && prev_in == 2'h3 && safety_in == 2'h2;
  endsequence

  sequence s_b_return;
    state == DCS_ST_UNEQUAL && odd_ch && prev_in == 2'h2 && safety_in == 2'h3;
  endsequence

  a_outputs_follow: assert property (@(posedge clk) disable iff (srst)
    run && state == DCS_ST_OK && next_state == DCS_ST_OK
      |=> safety_out_a == $past(safety_in.safety_in_a)
       && safety_out_b == $past(safety_in.safety_in_b))
    else $error("safety outputs did not follow inputs");

  a_absent_low: assert property (@(posedge clk) disable iff (srst)
    !actuator_present |=> !safety_out_a && !safety_out_b)
    else $error("outputs high without actuator");

  a_signal_presence: assert property (@(posedge clk) disable iff (srst)
    !fieldbus_attached |=> signal_diag_out == $past(actuator_present))
    else $error("signal output does not show presence");

  a_unequal_enter: assert property (@(posedge clk) disable iff (srst)
    s_a_drop |=> state == DCS_ST_UNEQUAL
      && indication == {DCS_IN_IND_FAST, DCS_DEV_IND_RED})
    else $error("unequal state not entered");

  a_lock_set: assert property (@(posedge clk) disable iff (srst)
    s_a_return |=> (plaus_error && !safety_out_a && !safety_out_b)
      ##1 (!safety_out_a && !safety_out_b))
    else $error("lock not set on return");

  a_lock_hold: assert property (@(posedge clk) disable iff (srst)
    state == DCS_ST_LOCK && !both_low |=> state == DCS_ST_LOCK)
    else $error("lock released without both low");

  a_diag_ignored: assert property (@(posedge clk) disable iff (srst)
    !fieldbus_attached |=> !diag_rx_data && !diag_rx_valid)
    else $error("diagnostic input used without module");

  a_diag_tx: assert property (@(posedge clk) disable iff (srst)
    fieldbus_attached |=> signal_diag_out == $past(diag_tx_data) && diag_active)
    else $error("signal output not carrying diagnostic data");

  a_powerup_low: assert property (@(posedge clk)
    $fell(srst) |-> (!safety_out_a && !safety_out_b) [*3])
    else $error("outputs rose before evaluation");

  a_lock_persist: assert property (@(posedge clk) disable iff (srst)
    plaus_error && !both_low |=> plaus_error)
    else $error("lock indication dropped early");

  // -------------------------------------------------------------------------
  // channel b mirrors, lock release, diagnostic and power-up checks
  // -------------------------------------------------------------------------
  a_unequal_enter_b: assert property (@(posedge clk) disable iff (srst)
    s_b_drop
      |=> state == DCS_ST_UNEQUAL && odd_ch)
    else $error("unequal state not entered for channel b");

  a_lock_set_b: assert property (@(posedge clk) disable iff (srst)
    s_b_return
      |=> plaus_error && !safety_out_a && !safety_out_b)
    else $error("lock not set on channel b return");

  a_lock_flash: assert property (@(posedge clk) disable iff (srst)
    plaus_error
      |-> indication == {DCS_IN_IND_FLASH, DCS_DEV_IND_RED})
    else $error("lock indication not shown");

  a_lock_block: assert property (@(posedge clk) disable iff (srst)
    state == DCS_ST_LOCK
      |=> !safety_out_a && !safety_out_b)
    else $error("outputs high while locked");

  a_lock_release: assert property (@(posedge clk) disable iff (srst)
    state == DCS_ST_LOCK && both_low
      |=> state == DCS_ST_OK && !plaus_error)
    else $error("lock not released after both low");

  a_unequal_follow: assert property (@(posedge clk) disable iff (srst)
    run && state == DCS_ST_UNEQUAL && next_state == DCS_ST_UNEQUAL
      |=> safety_out_a == $past(safety_in.safety_in_a)
       && safety_out_b == $past(safety_in.safety_in_b))
    else $error("outputs did not follow inputs while unequal");

  a_not_ready_low: assert property (@(posedge clk) disable iff (srst)
    !switch_ready
      |=> !safety_out_a && !safety_out_b)
    else $error("outputs high while switch not ready");

  a_unequal_hold: assert property (@(posedge clk) disable iff (srst)
    state == DCS_ST_UNEQUAL && !both_low && !odd_rose
      |=> state == DCS_ST_UNEQUAL)
    else $error("unequal state left without release");

  a_signal_absent: assert property (@(posedge clk) disable iff (srst)
    !fieldbus_attached && !actuator_present
      |=> !signal_diag_out)
    else $error("signal output high without actuator");

  a_diag_receive: assert property (@(posedge clk) disable iff (srst)
    fieldbus_attached
      |=> diag_rx_valid && diag_rx_data == $past(diag_in))
    else $error("diagnostic input not taken with module");

  a_diag_rejoin: assert property (@(posedge clk) disable iff (srst)
    $rose(fieldbus_attached)
      |=> diag_active && diag_rx_valid)
    else $error("diagnostic link not taken up again");

  a_eval_delay: assert property (@(posedge clk) disable iff (srst)
    $fell(srst)
      |-> !evaluated ##1 !evaluated ##1 evaluated)
    else $error("evaluation delay has wrong length");

endmodule
`default_nettype wire

// ---- dcs_bus_model.sv ----
// partner model: diagnostic fieldbus side of the safety output logic
`default_nettype none
module dcs_bus_model (
  input  wire logic        clk,
  input  wire logic        signal_diag_out,
  input  wire logic        diag_active,
  output var  logic        diag_in,
  output var  logic [15:0] chain_img
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] lfsr;
  localparam logic [7:0] NAME_EXP = 8'h5A;  // expected actuator name byte, value arbitrary
  logic [7:0] serial_prev;
  logic       exchange_seen;
  logic       name_match;
  // -------------------------------------------------------------------------
  // diagnostic input pattern
  // -------------------------------------------------------------------------
  initial begin
    lfsr = 8'hA5;
    diag_in = 1'b0;
    chain_img = 16'h0000;
  end
  // pattern shifts every cycle so a stale bit is caught wherever two successive bits differ
  always @(posedge clk) begin
    lfsr <= #2 {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    diag_in <= #2 lfsr[0];
  end
  // one received bit kept per subscriber, sixteen at the most
  always @(posedge clk) begin
    if (diag_active) chain_img <= {chain_img[14:0], signal_diag_out};
  end
  // far side reads identity and name bytes back out of the chain image
  always @(posedge clk) begin
    if (diag_active) begin
      serial_prev   <= chain_img[15:8];
      exchange_seen <= serial_prev != chain_img[15:8];
      name_match    <= chain_img[7:0] == NAME_EXP;
    end
  end
endmodule
`default_nettype wire

// ---- dcs_output_logic_tb_top.sv ----
// testbench: random and corner stimulus for the safety output logic
`default_nettype none
module dcs_output_logic_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import dcs_pkg::*;
  logic      clk, srst, present, ready, attached, tx, din;
  dcs_pair_t sin;
  logic      oa, ob, sdo, rxd, rxv, act, perr, pa, pb;
  logic      ea, eb, es, erd, erv, eperr;
  dcs_ind_t  ind, eind;
  int        err_count, n_checks, cyc, st;
  logic [5:0] corner [12] = '{6'h3C, 6'h1C, 6'h3C, 6'h2C, 6'h3C, 6'h0C,
                              6'h2C, 6'h3C, 6'h34, 6'h3A, 6'h3B, 6'h33};

  dcs_output_logic dut (.clk(clk), .srst(srst), .safety_in(sin),
    .actuator_present(present), .switch_ready(ready), .fieldbus_attached(attached),
    .diag_in(din), .diag_tx_data(tx), .safety_out_a(oa), .safety_out_b(ob),
    .signal_diag_out(sdo), .diag_rx_data(rxd), .diag_rx_valid(rxv),
    .diag_active(act), .plaus_error(perr), .indication(ind));
  dcs_bus_model bus (.clk(clk), .signal_diag_out(sdo), .diag_active(act),
    .diag_in(din), .chain_img());

  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic chk(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_ind(input dcs_ind_t got, input dcs_ind_t exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // reference monitor: works out what the next edge must show
  task automatic predict();
    logic a, b;
    a = sin.safety_in_a;
    b = sin.safety_in_b;
    if (st == 0 && pa && pb && (a ^ b)) st = 1;
    else if (st != 0 && !a && !b) st = 0;
    else if (st == 1 && a && b) st = 2;
    pa = a;
    pb = b;
    ea = present & ready & (st != 2) & a;
    eb = present & ready & (st != 2) & b;
    eperr = (st == 2);
    es = attached ? tx : present;
    erd = attached & din;
    erv = attached;
    if (st == 0) eind = {(a & b) ? DCS_IN_IND_ON : DCS_IN_IND_OFF,
                         ready ? DCS_DEV_IND_GREEN : DCS_DEV_IND_OFF};
    else eind = {(st == 1) ? DCS_IN_IND_FAST : DCS_IN_IND_FLASH, DCS_DEV_IND_RED};
  endtask

  // one cycle: drive {a, b, present, ready, attached, tx}, check after the edge
  task automatic step(input logic [5:0] v, input int mode);
    {sin, present, ready, attached, tx} = v;
    #1;
    predict();
    @(posedge clk);
    #1;
    if (mode == 1) begin
      chk(oa, ea);
      chk(ob, eb);
      chk(perr, eperr);
      chk(sdo, es);
      chk(rxd, erd);
      chk(rxv, erv);
      chk(act, erv);
      chk_ind(ind, eind);
    end
    if (mode == 2) begin
      chk(oa, 1'b0);
      chk(ob, 1'b0);
    end
    #1;
  endtask

  task automatic do_reset();
    srst = 1'b1;
    {sin, present, ready, attached, tx} = 6'h3C;
    repeat (4) @(posedge clk);
    #1;
    chk(oa, 1'b0);
    chk(ob, 1'b0);
    chk(perr, 1'b0);
    #1;
    srst = 1'b0;
    st = 0;
    pa = 1'b0;
    pb = 1'b0;
    step(6'h3C, 2);
    step(6'h3C, 2);
  endtask

  // -------------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------------
  initial begin
    logic [5:0] v;
    int k;
    err_count = 0;
    n_checks = 0;
    cyc = 0;
    void'($urandom(57));
    for (int r = 0; r < 2; r++) begin
      do_reset();
      foreach (corner[i]) step(corner[i], 1);
      for (int i = 0; i < 900; i++) begin
        v = {sin, 4'h0};
        k = $urandom % 6;
        if (k < 2) v[4 + k] = ~v[4 + k];
        v[3] = ($urandom % 8) != 0;
        v[2] = ($urandom % 8) != 0;
        v[1] = $urandom % 2;
        v[0] = $urandom % 2;
        step(v, 1);
      end
    end
    end_sim();
  end
endmodule
`default_nettype wire
